//--- pin_change_interrupt.sv
// Pin-change interrupt detector for three 8-bit ports with an AHB-Lite register slave.
//
// Operation
// - Summary request to core only while master enabled; status irq ignores master
// - Detection and flags run regardless of master
// - Per-pin rising detector gated by enable bit
// - Per-pin falling detector gated by enable bit
// - Both enables set flag either edge
// - Enabled edge sets flag until software clears
// - Summary request is OR of all flags
// - Summary bit ignores writes
// - Edge during flag write leaves flag set
// - Pin change wakes Sleep when master enabled
// - Sleep edge recorded before first instruction
// - Reset-pin or LOW_VOLTAGE_PROG_ENABLE config disables that pin
`timescale 1ns/1ps

module pin_change_interrupt
  import pin_change_pkg::*;
#(
  parameter int NUM_PORTS  = 3,
  parameter int PORT_WIDTH = 8
)
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Port pins.
  input  wire logic [7:0]  port_a_pins,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic [7:0]  port_c_pins,
  // Core side.
  output logic             pin_change_irq,
  output logic             pin_change_wake,
  output logic             irq
);

  logic [7:0] rise_r [3];
  logic [7:0] fall_r [3];
  logic [7:0] flags_r [3];
  logic [2:0] ctrl_r;
  logic [STAT_WIDTH-1:0] stat_r;
  logic [STAT_WIDTH-1:0] imask_r;

  logic [7:0] sync1_r [3];
  logic [7:0] sync2_r [3];
  logic [7:0] prev_r [3];
  logic [7:0] rise_hit [3];
  logic [7:0] fall_hit [3];
  logic [7:0] edge_hit [3];
  logic [7:0] pin_avail [3];
  logic       any_edge;
  logic       summary;

  // Data-phase capture.
  logic        dp_valid_r;
  logic        dp_write_r;
  logic [15:0] dp_idx_r;

  logic        addr_take;
  logic        wr_now;
  logic        rd_now;
  logic [31:0] rd_data;

  // Register strobes, one bit per port where each port has its own register.
  // They are decoded once so that every register process tests a single bit.
  logic [2:0]            wr_rise_sel;
  logic [2:0]            wr_fall_sel;
  logic [2:0]            wr_flag_sel;
  logic                  wr_ctrl_sel;
  logic                  wr_imask_sel;
  logic                  rd_status_sel;
  logic [STAT_WIDTH-1:0] stat_ev;

  // The register map and the pin tables are laid out for three byte-wide ports.
  if (NUM_PORTS != 3 || PORT_WIDTH != 8) begin : g_size_check
    $error("pin_change_interrupt serves exactly three ports of eight pins");
  end

  // Returns the port number addressed by an index, or 3 when none.
  function automatic logic [1:0] port_of(input logic [15:0] idx, input logic [15:0] base0,
                                         input logic [15:0] base1, input logic [15:0] base2);
    if (idx == base0) begin
      return 2'h0;
    end else if (idx == base1) begin
      return 2'h1;
    end else if (idx == base2) begin
      return 2'h2;
    end else begin
      return 2'h3;
    end
  endfunction

  // Returns a one-hot port select for an index, or zero when no port matches.
  function automatic logic [2:0] onehot_of(input logic [15:0] idx, input logic [15:0] base0,
                                           input logic [15:0] base1, input logic [15:0] base2);
    logic [2:0] sel;
    sel    = 3'h0;
    sel[0] = (idx == base0);
    sel[1] = (idx == base1);
    sel[2] = (idx == base2);
    return sel;
  endfunction

  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
  assign wr_now    = dp_valid_r && dp_write_r;
  assign rd_now    = addr_take && !hwrite;

  // Write strobes decoded from the index held over into the data phase.
  always_comb begin
    wr_rise_sel  = 3'h0;
    wr_fall_sel  = 3'h0;
    wr_flag_sel  = 3'h0;
    wr_ctrl_sel  = 1'b0;
    wr_imask_sel = 1'b0;
    if (wr_now) begin
      wr_rise_sel  = onehot_of(dp_idx_r, IDX_RISE_A, IDX_RISE_B, IDX_RISE_C);
      wr_fall_sel  = onehot_of(dp_idx_r, IDX_FALL_A, IDX_FALL_B, IDX_FALL_C);
      wr_flag_sel  = onehot_of(dp_idx_r, IDX_FLAGS_A, IDX_FLAGS_B, IDX_FLAGS_C);
      wr_ctrl_sel  = (dp_idx_r == IDX_CTRL);
      wr_imask_sel = (dp_idx_r == IDX_IMASK);
    end
  end

  // A status read clears in its address phase, at the edge that also captures the read data.
  assign rd_status_sel = rd_now && (haddr[17:2] == IDX_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_idx_r   <= 16'h0000;
    end else if (hready) begin
      dp_valid_r <= addr_take;
      dp_write_r <= hwrite;
      dp_idx_r   <= haddr[17:2];
    end
  end

  // Pin availability; unimplemented pins never flag.
  // The reset pin drops out under either config bit, since it then has no port function.
  always_comb begin
    pin_avail[0] = PORT_A_PINS;
    pin_avail[1] = PORT_B_PINS;
    pin_avail[2] = PORT_C_PINS;
    if (ctrl_r[CTRL_RST_PIN_BIT] || ctrl_r[CTRL_LVP_BIT]) begin
      pin_avail[0][RESET_PIN_IDX] = 1'b0;
    end
  end

  // Two-flop synchroniser; only the second stage is read by the edge logic.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < 3; p++) begin
        sync1_r[p] <= PORT_RESET;
        sync2_r[p] <= PORT_RESET;
      end
    end else begin
      sync1_r[0] <= port_a_pins;
      sync1_r[1] <= port_b_pins;
      sync1_r[2] <= port_c_pins;
      for (int p = 0; p < 3; p++) begin
        sync2_r[p] <= sync1_r[p];
      end
    end
  end

  // Previous sample; it resets to the idle pin level so that no false edge follows reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < 3; p++) begin
        prev_r[p] <= PORT_RESET;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        prev_r[p] <= sync2_r[p];
      end
    end
  end

  // Rising and falling detectors per pin, each gated by its own enable bit.
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      rise_hit[p] = sync2_r[p] & ~prev_r[p] & rise_r[p];
      fall_hit[p] = ~sync2_r[p] & prev_r[p] & fall_r[p];
      edge_hit[p] = (rise_hit[p] | fall_hit[p]) & pin_avail[p];
    end
  end

  assign any_edge = |(edge_hit[0] | edge_hit[1] | edge_hit[2]);
  assign summary  = |(flags_r[0] | flags_r[1] | flags_r[2]);

  // Rising-edge enable registers.
  // All eight bits are kept; unimplemented pins are masked later in the detector.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < 3; p++) begin
        rise_r[p] <= PORT_RESET;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (wr_rise_sel[p]) begin
          rise_r[p] <= hwdata[7:0];
        end
      end
    end
  end

  // Falling-edge enable registers.
  // Both enables of a pin may be set together to catch either edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < 3; p++) begin
        fall_r[p] <= PORT_RESET;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (wr_fall_sel[p]) begin
          fall_r[p] <= hwdata[7:0];
        end
      end
    end
  end

  // Flags: set by edges whatever the master enable, and a same-cycle edge beats a write.
  // Software that clears only the bits it has seen set therefore keeps an edge that lands in the write cycle, but not one between its read and its write.
  // Writing a one sets a flag, which lets software raise a request on purpose.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < 3; p++) begin
        flags_r[p] <= PORT_RESET;
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (wr_flag_sel[p]) begin
          flags_r[p] <= (hwdata[7:0] & pin_avail[p]) | edge_hit[p];
        end else begin
          flags_r[p] <= flags_r[p] | edge_hit[p];
        end
      end
    end
  end

  // Control register; the summary bit is never written.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_ctrl_sel) begin
      ctrl_r <= hwdata[2:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imask_r <= IMASK_RESET;
    end else if (wr_imask_sel) begin
      imask_r <= hwdata[STAT_WIDTH-1:0];
    end
  end

  // Status events: a flag pending anywhere, and an edge seen in this cycle.
  always_comb begin
    stat_ev                   = '0;
    stat_ev[STAT_SUMMARY_BIT] = summary;
    stat_ev[STAT_EDGE_BIT]    = any_edge;
  end

  // Sticky status, cleared by a read; an event in the read cycle is kept, so none is lost.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= STAT_RESET;
    end else if (rd_status_sel) begin
      stat_r <= stat_ev;
    end else begin
      stat_r <= stat_r | stat_ev;
    end
  end

  // Request to the core, gated by the master enable; the flags keep running without it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_change_irq <= 1'b0;
    end else begin
      pin_change_irq <= summary && ctrl_r[CTRL_MASTER_EN_BIT];
    end
  end

  // Wake also follows an edge of the current cycle, so the flag is set before the core runs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_change_wake <= 1'b0;
    end else begin
      pin_change_wake <= (summary || any_edge) && ctrl_r[CTRL_MASTER_EN_BIT];
    end
  end

  // Level interrupt, high while an unmasked status bit is set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_r & imask_r);
    end
  end

  // Read mux, decoded from the address phase.
  // Unmapped indices and unused bits read as zero.
  always_comb begin
    logic [15:0] idx;
    idx     = haddr[17:2];
    rd_data = 32'h0000_0000;
    if (port_of(idx, IDX_RISE_A, IDX_RISE_B, IDX_RISE_C) != 2'h3) begin
      rd_data[7:0] = rise_r[port_of(idx, IDX_RISE_A, IDX_RISE_B, IDX_RISE_C)];
    end else if (port_of(idx, IDX_FALL_A, IDX_FALL_B, IDX_FALL_C) != 2'h3) begin
      rd_data[7:0] = fall_r[port_of(idx, IDX_FALL_A, IDX_FALL_B, IDX_FALL_C)];
    end else if (port_of(idx, IDX_FLAGS_A, IDX_FLAGS_B, IDX_FLAGS_C) != 2'h3) begin
      rd_data[7:0] = flags_r[port_of(idx, IDX_FLAGS_A, IDX_FLAGS_B, IDX_FLAGS_C)];
    end else if (idx == IDX_CTRL) begin
      rd_data[2:0] = ctrl_r;
      rd_data[3]   = summary;
    end else if (idx == IDX_STATUS) begin
      rd_data[STAT_WIDTH-1:0] = stat_r;
    end else if (idx == IDX_IMASK) begin
      rd_data[STAT_WIDTH-1:0] = imask_r;
    end
  end

  // Read data registered at the address phase, presented in the data phase.
  // It holds until the next read, so the master may take it at any later edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_now) begin
      hrdata <= rd_data;
    end
  end

  // Every transfer completes with no wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // Every response is OKAY, unmapped addresses included.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

endmodule

//--- pin_change_pkg.sv
// Package with register map, field positions and reset values of the pin-change block.
package pin_change_pkg;

  // Printed offsets are not multiples of four: each is a register index, byte address = 4 * index.
  localparam logic [15:0] IDX_RISE_A  = 16'h1F3D;
  localparam logic [15:0] IDX_FALL_A  = 16'h1F3E;
  localparam logic [15:0] IDX_FLAGS_A = 16'h1F3F;
  localparam logic [15:0] IDX_RISE_B  = 16'h1F48;
  localparam logic [15:0] IDX_FALL_B  = 16'h1F49;
  localparam logic [15:0] IDX_FLAGS_B = 16'h1F4A;
  localparam logic [15:0] IDX_RISE_C  = 16'h1F53;
  localparam logic [15:0] IDX_FALL_C  = 16'h1F54;
  localparam logic [15:0] IDX_FLAGS_C = 16'h1F55;
  localparam logic [15:0] IDX_CTRL    = 16'h1F60;
  localparam logic [15:0] IDX_STATUS  = 16'h1F61;
  localparam logic [15:0] IDX_IMASK   = 16'h1F62;

  // Control register fields.
  localparam int CTRL_MASTER_EN_BIT = 0;
  localparam int CTRL_RST_PIN_BIT   = 1;
  localparam int CTRL_LVP_BIT       = 2;

  // Status and interrupt mask fields.
  localparam int STAT_SUMMARY_BIT = 0;
  localparam int STAT_EDGE_BIT    = 1;
  localparam int STAT_WIDTH       = 2;

  // Pin index within port A that doubles as the external reset pin.
  localparam int RESET_PIN_IDX = 3;

  localparam logic [7:0]            PORT_RESET  = 8'h00;
  localparam logic [2:0]            CTRL_RESET  = 3'h0;
  localparam logic [STAT_WIDTH-1:0] STAT_RESET  = 2'h0;
  localparam logic [STAT_WIDTH-1:0] IMASK_RESET = 2'h0;

  // Implemented pins per port.
  localparam logic [7:0] PORT_A_PINS = 8'h3F;
  localparam logic [7:0] PORT_B_PINS = 8'hF0;
  localparam logic [7:0] PORT_C_PINS = 8'hFF;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

//--- pin_change_asserts.sv
// Checks on bus answers and request edges of the pin-change block.
`timescale 1ns/1ps
module pin_change_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        hwrite,
  input wire logic [7:0]  port_a_pins,
  input wire logic [7:0]  port_b_pins,
  input wire logic [7:0]  port_c_pins,
  input wire logic        pin_change_irq,
  input wire logic        pin_change_wake,
  input wire logic        irq
);
  logic       acc;
  logic [7:0] acc_h_r;
  logic [7:0] chg_h_r;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign acc = hsel && hready && htrans == 2'h2;
  // Bus accesses and pin changes are the only causes that may move a request.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_h_r <= 8'h00;
      chg_h_r <= 8'h00;
    end else begin
      acc_h_r <= {acc_h_r[6:0], acc};
      chg_h_r <= {chg_h_r[6:0], $changed({port_a_pins, port_b_pins, port_c_pins})};
    end
  end
  property p_ready; hreadyout == 1'h1; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; hresp == 1'h0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_upper; hrdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_stands; !(acc && !hwrite) |=> $stable(hrdata); endproperty
  a_stands: assert property (p_stands) else $error("read data moved");
  property p_wake; pin_change_irq |-> pin_change_wake; endproperty
  a_wake: assert property (p_wake) else $error("request without wake");
  property p_hold; $fell(pin_change_irq) |-> acc_h_r != 8'h00; endproperty
  a_hold: assert property (p_hold) else $error("request fell alone");
  property p_rise; $rose(pin_change_irq) |-> (acc_h_r | chg_h_r) != 8'h00; endproperty
  a_rise: assert property (p_rise) else $error("request rose alone");
  property p_lvl; $fell(irq) |-> acc_h_r != 8'h00; endproperty
  a_lvl: assert property (p_lvl) else $error("irq fell alone");
  c_req: cover property ($rose(pin_change_irq));
  c_clr: cover property ($fell(pin_change_irq));
  c_irq: cover property ($fell(irq));
endmodule
bind pin_change_interrupt pin_change_asserts u_chk (.*);

//--- pin_source.sv
// Model of the external levels on the three ports.
`timescale 1ns/1ps
module pin_source (
  output logic [7:0] port_a_pins,
  output logic [7:0] port_b_pins,
  output logic [7:0] port_c_pins
);
  // Levels move right after a clock edge, like any unsynchronised source.
  task automatic drive(input logic [23:0] v);
    {port_a_pins, port_b_pins, port_c_pins} <= v;
  endtask
endmodule

//--- tb_pin_change_interrupt.sv
// Self-checking bench of the pin-change block.
`timescale 1ns/1ps
module tb_pin_change_interrupt
  import pin_change_pkg::*;
;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  port_a_pins;
  logic [7:0]  port_b_pins;
  logic [7:0]  port_c_pins;
  logic        pin_change_irq;
  logic        pin_change_wake;
  logic        irq;
  logic [31:0] rd;
  int          errors = 0;
  int          checks = 0;
  assign hready = hreadyout;
  always #20 hclk = ~hclk;
  pin_source pins_u (.*);
  pin_change_interrupt dut_u (.*);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hready === 1'h1) return;
    end
    chk("hready", 32'h0, 32'h1);
    give_verdict();
  endtask
  task automatic bus(input logic w, input logic [15:0] ix, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {14'h0, ix, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_ready();
    rd = hrdata;
  endtask
  task automatic rchk(input string n, input logic [15:0] ix, input logic [31:0] e);
    bus(1'h0, ix, 8'h00);
    chk(n, rd, e);
  endtask
  task automatic step(input logic [23:0] v);
    @(posedge hclk);
    pins_u.drive(v);
    idle(5);
  endtask
  task automatic t_edges();
    bus(1'h1, 16'h1F40, 8'hFF);
    rchk("unmapped", 16'h1F40, 32'h0);
    rchk("flags_c", IDX_FLAGS_C, 32'h0);
    bus(1'h1, IDX_RISE_C, 8'h8F);
    bus(1'h1, IDX_FALL_C, 8'hF0);
    step(24'h0000FF);
    rchk("rise_c", IDX_FLAGS_C, 32'h8F);
    chk("irq_off", 32'(pin_change_irq), 32'h0);
    bus(1'h1, IDX_FLAGS_C, 8'h00);
    step(24'h000000);
    rchk("fall_c", IDX_FLAGS_C, 32'hF0);
  endtask
  task automatic t_master();
    bus(1'h1, IDX_FLAGS_C, 8'h00);
    bus(1'h1, IDX_CTRL, 8'h09);
    rchk("ctrl", IDX_CTRL, 32'h1);
    step(24'h000001);
    chk("irq_on", 32'(pin_change_irq), 32'h1);
    chk("wake", 32'(pin_change_wake), 32'h1);
    rchk("summary", IDX_CTRL, 32'h9);
    bus(1'h1, IDX_FLAGS_C, 8'h00);
    idle(2);
    chk("irq_clr", 32'(pin_change_irq), 32'h0);
  endtask
  task automatic t_race();
    bus(1'h1, IDX_RISE_B, 8'h30);
    step(24'h001001);
    rchk("flags_b", IDX_FLAGS_B, 32'h10);
    @(posedge hclk);
    pins_u.drive(24'h003001);
    bus(1'h1, IDX_FLAGS_B, rd[7:0] & ~8'h10);
    rchk("race_b", IDX_FLAGS_B, 32'h20);
  endtask
  task automatic t_reset_pin();
    logic [7:0] cv [3] = '{8'h03, 8'h05, 8'h01};
    logic [7:0] ev [3] = '{8'h01, 8'h01, 8'h09};
    bus(1'h1, IDX_RISE_A, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      bus(1'h1, IDX_CTRL, cv[k]);
      step(24'hC93001);
      rchk("flags_a", IDX_FLAGS_A, {24'h0, ev[k]});
      step(24'h003001);
      bus(1'h1, IDX_FLAGS_A, 8'h00);
    end
  endtask
  task automatic t_status();
    bus(1'h1, IDX_IMASK, 8'h02);
    step(24'h003003);
    chk("irq_set", 32'(irq), 32'h1);
    bus(1'h0, IDX_STATUS, 8'h00);
    chk("status", rd & 32'h2, 32'h2);
    idle(2);
    chk("irq_read", 32'(irq), 32'h0);
    bus(1'h1, IDX_IMASK, 8'h00);
    step(24'h003007);
    chk("irq_mask", 32'(irq), 32'h0);
    bus(1'h1, IDX_IMASK, 8'h02);
    idle(2);
    chk("irq_unmask", 32'(irq), 32'h1);
  endtask
  initial begin
    pins_u.drive(24'h000000);
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    t_edges();
    t_master();
    t_race();
    t_reset_pin();
    t_status();
    give_verdict();
  end
endmodule
